// File: lintc_core.sv
// lintc: LIN transceiver mode, wake-up and termination control with Avalon-MM registers
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module lintc_core import lintc_pkg::*; #(
	parameter int unsigned WAKE_CYCLES = WAKE_CYC,
	parameter int unsigned DOM_CYCLES  = DOM_CYC,
	parameter int unsigned RST_CYCLES  = RST_CYC
) (
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	// avalon-mm slave
	input  wire logic [3:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// system controller
	input  wire logic [MODE_W-1:0] sys_mode_i,
	input  wire logic              failsafe_wake_fail_i,
	// lin bus side
	input  wire logic              lin_bus_i,
	input  wire logic              lin_txd_i,
	output logic                   lin_tx_enable_o,
	output logic                   lin_tx_o,
	output logic                   lin_receive_wake_out_o,
	output logic                   term_strong_o,
	output logic                   term_high_batt_o,
	output logic                   term_weak_o,
	output logic                   rx_ref_12v_o,
	// host pins
	output logic                   system_reset_out_n_o,
	output logic                   irq_out_n_o
);
	// a reset pulse shorter than two cycles may be missed by the host
	if (WAKE_CYCLES < 1 || DOM_CYCLES <= WAKE_CYCLES
		|| RST_CYCLES < 2 || RST_CYCLES > 65535) begin : g_bad_params
		$error("lintc_core: timing parameters out of range");
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic mode_is_active(input logic [MODE_W-1:0] m);
		return (m == MODE_NORMAL) || (m == MODE_FLASH);
	endfunction : mode_is_active

	function automatic logic mode_is_unpowered(input logic [MODE_W-1:0] m);
		return (m == MODE_SLEEP) || (m == MODE_FAILSAFE);
	endfunction : mode_is_unpowered

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	lintc_link_t       link;
	lintc_term_t       term;
	logic [2:0]        ctrl;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic [IRQ_W-1:0]  rd_irq_snap;
	logic              irq_any;
	logic              ack;
	logic              wr_go;
	logic              rd_go;
	logic              wake_flag;
	logic              short_gnd;
	logic              bus_dom;
	logic              mode_active;
	logic              enter_on;
	logic              wake_exp;
	logic              dom_exp;
	logic              wake_evt;
	logic              short_set;
	logic              short_clr;
	logic              rst_req;
	logic              irq_req;
	logic              rst_active;
	logic [15:0]       rst_cnt;

	assign bus_dom     = !lin_bus_i;
	assign mode_active = mode_is_active(sys_mode_i);
	assign enter_on    = (link == LINK_OFF) && mode_active;

	// ------------------------------------------------------------------
	// avalon-mm slave: one wait cycle, then the answer
	// ------------------------------------------------------------------
	// waitrequest drops on the second cycle of every request
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
	assign wr_go = avs_write_i && ack;
	assign rd_go = avs_read_i && ack;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read_i || avs_write_i) && !ack;
		end
	end

	// read data is captured in the wait cycle; unmapped addresses read zero
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h0;
			rd_irq_snap    <= '0;
		end else if (avs_read_i && !ack) begin
			rd_irq_snap    <= (avs_address_i == ADDR_IRQ) ? irq_status : '0;
			unique case (avs_address_i)
				ADDR_CTRL:   avs_readdata_o <= {29'h0, ctrl};
				ADDR_STATUS: avs_readdata_o <= {26'h0, term, short_gnd, wake_flag,
					link == LINK_ON};
				ADDR_IRQ:    avs_readdata_o <= {30'h0, irq_status};
				ADDR_MASK:   avs_readdata_o <= {30'h0, irq_mask};
				default:     avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// control and mask registers, low byte lane only
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl     <= CTRL_RST;
			irq_mask <= MASK_RST;
		end else if (wr_go && avs_byteenable_i[0]) begin
			if (avs_address_i == ADDR_CTRL) begin
				ctrl <= avs_writedata_i[2:0];
			end
			if (avs_address_i == ADDR_MASK) begin
				irq_mask <= avs_writedata_i[IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// duration counters on the chip clock
	// ------------------------------------------------------------------
	// wake time only counts off-line; the time-out restarts on on-line entry
	lintc_timer #(.LIMIT(WAKE_CYCLES)) u_wake_tmr (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.run_i      (bus_dom && link == LINK_OFF),
		.expired_o  (wake_exp)
	);

	lintc_timer #(.LIMIT(DOM_CYCLES)) u_dom_tmr (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.run_i      (bus_dom && !enter_on),
		.expired_o  (dom_exp)
	);

	// ------------------------------------------------------------------
	// link state and wake flag
	// ------------------------------------------------------------------
	// long dominant then first recessive cycle; the counter clears on that edge
	assign wake_evt = (link == LINK_OFF) && wake_exp && !bus_dom;

	// power-on lands off-line; the link follows the system mode
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			link <= LINK_OFF;
		end else begin
			link <= mode_active ? LINK_ON : LINK_OFF;
		end
	end

	// set wins over either clear so no wake-up slips through
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wake_flag <= 1'b0;
		end else if (wake_evt) begin
			wake_flag <= 1'b1;
		end else if (mode_active) begin
			wake_flag <= 1'b0;
		end else if (failsafe_wake_fail_i) begin
			wake_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// ground short detection and termination
	// ------------------------------------------------------------------
	assign short_set = dom_exp && !short_gnd;
	assign short_clr = short_gnd && (!bus_dom || enter_on);

	// on-line entry forgets an older short; recessive bus ends it
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			short_gnd <= 1'b0;
		end else if (enter_on) begin
			short_gnd <= 1'b0;
		end else if (short_set) begin
			short_gnd <= 1'b1;
		end else if (!bus_dom) begin
			short_gnd <= 1'b0;
		end
	end

	// termination switch choice
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			term <= TERM_WEAK;
		end else if (link == LINK_ON) begin
			term <= short_gnd ? TERM_WEAK : TERM_STRONG;
		end else begin
			term <= short_gnd ? TERM_FLOAT : TERM_WEAK;
		end
	end

	assign term_strong_o = term[2];
	assign term_weak_o   = term[1];

	// supply select for the switch and the receiver reference
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			term_high_batt_o <= 1'b0;
			rx_ref_12v_o     <= 1'b0;
		end else begin
			term_high_batt_o <= ctrl[CTRL_HBTS];
			rx_ref_12v_o     <= ctrl[CTRL_HBTS];
		end
	end

	// ------------------------------------------------------------------
	// transmitter and receive output
	// ------------------------------------------------------------------
	// one cycle of latency on receive data, harmless at lin bit rates
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lin_tx_enable_o        <= 1'b0;
			lin_tx_o               <= 1'b1;
			lin_receive_wake_out_o <= 1'b1;
		end else if (link == LINK_ON) begin
			lin_tx_enable_o        <= ctrl[CTRL_TXC];
			lin_tx_o               <= ctrl[CTRL_TXC] ? lin_txd_i : 1'b1;
			lin_receive_wake_out_o <= lin_bus_i;
		end else begin
			lin_tx_enable_o        <= 1'b0;
			lin_tx_o               <= 1'b1;
			lin_receive_wake_out_o <= !wake_flag;
		end
	end

	// ------------------------------------------------------------------
	// wake reaction: reset pulse or interrupt
	// ------------------------------------------------------------------
	// in normal mode the link is on-line, so no wake-up is seen there
	assign rst_req = wake_evt && (mode_is_unpowered(sys_mode_i)
		|| (sys_mode_i == MODE_STANDBY && !ctrl[CTRL_WIE]));
	assign irq_req = wake_evt && sys_mode_i == MODE_STANDBY && ctrl[CTRL_WIE];

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rst_cnt    <= 16'h0;
			rst_active <= 1'b0;
		end else if (rst_req) begin
			rst_cnt    <= 16'(RST_CYCLES - 1);
			rst_active <= 1'b1;
		end else if (rst_cnt != 16'h0) begin
			rst_cnt    <= rst_cnt - 16'h1;
		end else begin
			rst_active <= 1'b0;
		end
	end

	assign system_reset_out_n_o = !rst_active;

	// read clears only the bits it returned; write one also clears
	assign irq_set = {short_set || short_clr, irq_req};
	assign irq_clr = (rd_go ? rd_irq_snap : '0)
		| ((wr_go && avs_address_i == ADDR_IRQ && avs_byteenable_i[0])
		? avs_writedata_i[IRQ_W-1:0] : '0);

	lintc_irq #(.W(IRQ_W)) u_irq (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.set_i      (irq_set),
		.clr_i      (irq_clr),
		.flush_i    (rst_active),
		.mask_i     (irq_mask),
		.status_o   (irq_status),
		.irq_o      (irq_any)
	);

	assign irq_out_n_o = !irq_any;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_wake_quiet;
		wake_evt && !mode_active ##1 !mode_active;
	endsequence

	chk_offline_txoff: assert property ((link == LINK_OFF) |=> !lin_tx_enable_o)
		else $error("transmitter enabled while off-line");
	chk_wake_rxd_low: assert property (s_wake_quiet |=> !lin_receive_wake_out_o)
		else $error("receive output not low after wake-up");
	chk_wake_cause: assert property (wake_evt |-> $past(bus_dom) && !bus_dom)
		else $error("wake-up without long dominant then recessive");
	chk_active_clear: assert property (mode_active && !wake_evt |=> !wake_flag && link == LINK_ON)
		else $error("active mode did not clear flag or go on-line");
	chk_fs_clear: assert property (failsafe_wake_fail_i && !wake_evt |=> !wake_flag)
		else $error("fail-safe entry did not clear wake flag");
	chk_sleep_reset: assert property (wake_evt && mode_is_unpowered(sys_mode_i)
		|=> !system_reset_out_n_o [*2])
		else $error("sleep wake-up gave no reset");
	chk_standby_irq: assert property (irq_req && irq_mask[IRQ_WAKE]
		|=> !irq_out_n_o && system_reset_out_n_o)
		else $error("standby wake-up with irq enable gave no interrupt");
	chk_irq_hold: assert property (!irq_out_n_o && !rd_go && !wr_go && !rst_active
		|=> !irq_out_n_o)
		else $error("interrupt dropped without a register access");
	chk_online_term: assert property ((link == LINK_ON) && !short_gnd
		|=> term_strong_o && term_high_batt_o == $past(ctrl[CTRL_HBTS]))
		else $error("on-line termination not strong on selected supply");
	chk_short_term: assert property (short_gnd |=> !term_strong_o)
		else $error("strong termination while shorted");
	chk_entry_strong: assert property (enter_on |=> !short_gnd ##1 term_strong_o)
		else $error("on-line entry did not force strong switch");
endmodule : lintc_core

// File: lintc_timer.sv
// lintc package (shared constants) and the dominant-level duration timer
`timescale 1ns/10ps
package lintc_pkg;
	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned WAKE_TIME_NS   = 50000;     // least dominant time for wake-up
	localparam int unsigned DOM_TIMEOUT_NS = 6000000;   // dominant time-out (clamp detect)
	localparam int unsigned RST_PULSE_NS   = 20000;     // length of the wake reset pulse
	localparam int unsigned WAKE_CYC       = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DOM_CYC        = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_CYC        = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// system modes as reported by the system controller
	// ------------------------------------------------------------------
	localparam int unsigned MODE_W        = 3;
	localparam logic [2:0]  MODE_NORMAL   = 3'h0;
	localparam logic [2:0]  MODE_FLASH    = 3'h1;
	localparam logic [2:0]  MODE_STANDBY  = 3'h2;
	localparam logic [2:0]  MODE_SLEEP    = 3'h3;
	localparam logic [2:0]  MODE_FAILSAFE = 3'h4;

	// ------------------------------------------------------------------
	// register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_IRQ    = 4'h8;
	localparam logic [3:0]  ADDR_MASK   = 4'hc;
	localparam int unsigned CTRL_TXC    = 0;    // bus_tx_control_bit
	localparam int unsigned CTRL_HBTS   = 1;    // high_battery_term_select
	localparam int unsigned CTRL_WIE    = 2;    // bus_wake_irq_enable
	localparam logic [2:0]  CTRL_RST    = 3'h0;
	localparam int unsigned ST_ONLINE   = 0;
	localparam int unsigned ST_WAKE     = 1;
	localparam int unsigned ST_SHORT    = 2;
	localparam int unsigned ST_TERM     = 3;    // three bits, one-hot termination state
	localparam int unsigned IRQ_W       = 2;
	localparam int unsigned IRQ_WAKE    = 0;
	localparam int unsigned IRQ_SHORT   = 1;
	localparam logic [1:0]  MASK_RST    = 2'h3;

	// ------------------------------------------------------------------
	// state types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {LINK_OFF = 2'b01, LINK_ON = 2'b10} lintc_link_t;
	typedef enum logic [2:0] {
		TERM_FLOAT  = 3'b001,
		TERM_WEAK   = 3'b010,
		TERM_STRONG = 3'b100
	} lintc_term_t;
endpackage : lintc_pkg

// counts consecutive cycles of run_i and saturates at LIMIT
module lintc_timer #(
	parameter int unsigned LIMIT = 16
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic run_i,
	output logic      expired_o
);
	localparam int unsigned CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);

	if (LIMIT < 1) begin : g_bad_limit
		$error("lintc_timer: LIMIT must be at least one");
	end

	logic [CW-1:0] cnt;

	// restart on every gap in run_i, hold at the limit
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt <= '0;
		end else if (!run_i) begin
			cnt <= '0;
		end else if (cnt != LIM) begin
			cnt <= cnt + CW'(1);
		end
	end

	assign expired_o = (cnt == LIM);
endmodule : lintc_timer

// File: lintc_irq.sv
// lintc sticky interrupt status with mask and a level interrupt
`timescale 1ns/10ps
module lintc_irq #(
	parameter int unsigned W = 2
) (
	input  wire logic         core_clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	input  wire logic         flush_i,
	input  wire logic [W-1:0] mask_i,
	output logic      [W-1:0] status_o,
	output logic              irq_o
);
	if (W < 1 || W > 32) begin : g_bad_width
		$error("lintc_irq: W must lie in 1..32");
	end

	// a set arriving together with a clear or a flush survives
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			status_o <= '0;
		end else if (flush_i) begin
			status_o <= set_i;
		end else begin
			status_o <= (status_o & ~clr_i) | set_i;
		end
	end

	assign irq_o = |(status_o & mask_i);
endmodule : lintc_irq

// File: lintc_bus_node.sv
// bus node model: drives its share of the single-wire bus, pulses or a clamp to ground
`timescale 1ns/10ps
module lintc_bus_node (
	input  wire logic core_clk_i,
	output logic      bus_o
);
	// the wire has a pull-up, so a silent node reads recessive
	initial begin
		bus_o = 1'h1;
	end

	// dominant pulse of n edges, then release; a long n plays a slow node
	task automatic dominant(input int n);
		@(posedge core_clk_i);
		bus_o <= 1'h0;
		repeat (n) @(posedge core_clk_i);
		bus_o <= 1'h1;
	endtask : dominant

	// hold the wire at a level, as a short to ground does, until told otherwise
	task automatic clamp(input logic v);
		@(posedge core_clk_i);
		bus_o <= v;
	endtask : clamp
endmodule : lintc_bus_node

// File: lintc_core_bench.sv
// self-checking bench for the transceiver mode, wake-up and termination control
`timescale 1ns/10ps
module lintc_core_bench import lintc_pkg::*;;
	// short counts keep the run brief; the wake and time-out waits below are derived from them
	localparam int unsigned WK = 4;
	localparam int unsigned DM = 12;

	logic              core_clk_i;
	logic              reset_i;
	logic [3:0]        avs_address_i;
	logic              avs_read_i;
	logic              avs_write_i;
	logic [31:0]       avs_writedata_i;
	logic [3:0]        avs_byteenable_i;
	logic [31:0]       avs_readdata_o;
	logic              avs_waitrequest_o;
	logic [MODE_W-1:0] sys_mode_i;
	logic              failsafe_wake_fail_i;
	logic              lin_bus_i;
	logic              lin_txd_i;
	logic              lin_tx_enable_o;
	logic              lin_tx_o;
	logic              lin_receive_wake_out_o;
	logic              term_strong_o;
	logic              term_high_batt_o;
	logic              term_weak_o;
	logic              rx_ref_12v_o;
	logic              system_reset_out_n_o;
	logic              irq_out_n_o;
	logic              node_bus;
	int                err_total = 0;
	int                comparisons = 0;
	logic [31:0]       exp_q[$];

	// wired-and bus: the node model and our own transmitter both pull it low
	assign lin_bus_i = node_bus & (lin_tx_enable_o ? lin_tx_o : 1'h1);

	initial begin
		core_clk_i = 1'h0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	lintc_core #(
		.WAKE_CYCLES(WK),
		.DOM_CYCLES (DM),
		.RST_CYCLES (3)
	) u_lintc_core (
		.core_clk_i            (core_clk_i),
		.reset_i               (reset_i),
		.avs_address_i         (avs_address_i),
		.avs_read_i            (avs_read_i),
		.avs_write_i           (avs_write_i),
		.avs_writedata_i       (avs_writedata_i),
		.avs_byteenable_i      (avs_byteenable_i),
		.avs_readdata_o        (avs_readdata_o),
		.avs_waitrequest_o     (avs_waitrequest_o),
		.sys_mode_i            (sys_mode_i),
		.failsafe_wake_fail_i  (failsafe_wake_fail_i),
		.lin_bus_i             (lin_bus_i),
		.lin_txd_i             (lin_txd_i),
		.lin_tx_enable_o       (lin_tx_enable_o),
		.lin_tx_o              (lin_tx_o),
		.lin_receive_wake_out_o(lin_receive_wake_out_o),
		.term_strong_o         (term_strong_o),
		.term_high_batt_o      (term_high_batt_o),
		.term_weak_o           (term_weak_o),
		.rx_ref_12v_o          (rx_ref_12v_o),
		.system_reset_out_n_o  (system_reset_out_n_o),
		.irq_out_n_o           (irq_out_n_o)
	);

	lintc_bus_node u_lintc_bus_node (
		.core_clk_i(core_clk_i),
		.bus_o     (node_bus)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one avalon cycle; for a read, d is the expected word and goes on the queue
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		if (!wr) exp_q.push_back(d);
		do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'h0);
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
	endtask : bus

	// read data are compared only at the edge that takes them
	always @(posedge core_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'h0 && exp_q.size() > 0) begin
			chk(avs_readdata_o, exp_q.pop_front());
		end
	end

	// mode is registered inside, so let it land before looking
	task automatic mode(input logic [2:0] m);
		@(posedge core_clk_i);
		sys_mode_i <= m;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : mode

	// dominant a little past the wake time, then recessive; returns once answers settle
	task automatic wake();
		u_lintc_bus_node.dominant(WK + 2);
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : wake

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : settle

	task automatic summarize();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// a hung handshake would otherwise stall the run forever
	initial begin
		#(5000 * CLK_PERIOD_NS);
		err_total++;
		summarize();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(10565));
		reset_i = 1'h1;
		avs_address_i = 4'h0;
		avs_read_i = 1'h0;
		avs_write_i = 1'h0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		sys_mode_i = MODE_STANDBY;
		failsafe_wake_fail_i = 1'h0;
		lin_txd_i = 1'h1;
		repeat (20) @(posedge core_clk_i);
		reset_i <= 1'h0;
		#1;
		chk(lin_receive_wake_out_o, 1'h1);
		chk(lin_tx_enable_o, 1'h0);
		chk({term_strong_o, term_weak_o}, 2'h1);
		chk({system_reset_out_n_o, irq_out_n_o}, 2'h3);
		bus(1'h0, ADDR_CTRL, 32'h0);
		bus(1'h0, ADDR_STATUS, 32'h10);
		bus(1'h0, ADDR_MASK, 32'h3);
		bus(1'h0, 4'h2, 32'h0);
		// sleep wake must reset with the interrupt enable clear
		mode(MODE_SLEEP);
		wake();
		chk({lin_receive_wake_out_o, system_reset_out_n_o}, 2'h0);
		mode(MODE_FAILSAFE);
		@(posedge core_clk_i);
		failsafe_wake_fail_i <= 1'h1;
		@(posedge core_clk_i);
		failsafe_wake_fail_i <= 1'h0;
		settle(3);
		chk(lin_receive_wake_out_o, 1'h1);
		// standby with enable clear: reset; normal then clears the flag
		mode(MODE_STANDBY);
		wake();
		chk({lin_receive_wake_out_o, system_reset_out_n_o}, 2'h0);
		mode(MODE_NORMAL);
		bus(1'h0, ADDR_STATUS, 32'h21);
		chk({term_strong_o, term_weak_o}, 2'h2);
		// standby with enable set: interrupt held until the read
		mode(MODE_STANDBY);
		bus(1'h1, ADDR_CTRL, 32'h5);
		bus(1'h1, ADDR_IRQ, 32'h3);
		settle(1);
		chk({lin_tx_enable_o, irq_out_n_o}, 2'h1);
		wake();
		chk({lin_receive_wake_out_o, system_reset_out_n_o, irq_out_n_o}, 3'h2);
		settle(10);
		chk(irq_out_n_o, 1'h0);
		bus(1'h0, ADDR_IRQ, 32'h1);
		settle(1);
		chk(irq_out_n_o, 1'h1);
		// sleep wake with the interrupt enable still set must reset, not interrupt
		mode(MODE_SLEEP);
		wake();
		chk({system_reset_out_n_o, irq_out_n_o}, 2'h1);
		// flash goes on-line: transmitter under software control, receive follows the wire
		mode(MODE_FLASH);
		bus(1'h1, ADDR_CTRL, 32'h3);
		settle(2);
		chk({lin_tx_enable_o, term_high_batt_o, rx_ref_12v_o}, 3'h7);
		for (int i = 0; i < 12; i++) begin
			@(posedge core_clk_i);
			lin_txd_i <= 1'($urandom);
			settle(2);
			chk({lin_receive_wake_out_o, lin_tx_o}, {lin_txd_i, lin_txd_i});
		end
		bus(1'h1, ADDR_CTRL, 32'h1);
		lin_txd_i <= 1'h1;
		settle(DM + 4);
		chk({lin_tx_enable_o, term_high_batt_o, rx_ref_12v_o}, 3'h4);
		// short to ground on-line: weak source, recessive restores strong
		bus(1'h1, ADDR_IRQ, 32'h3);
		u_lintc_bus_node.clamp(1'h0);
		settle(DM + 4);
		chk({term_strong_o, term_weak_o}, 2'h1);
		u_lintc_bus_node.clamp(1'h1);
		settle(3);
		chk({term_strong_o, term_weak_o}, 2'h2);
		bus(1'h0, ADDR_IRQ, 32'h2);
		// short off-line floats; entering on-line forces strong until time-out
		mode(MODE_STANDBY);
		u_lintc_bus_node.clamp(1'h0);
		settle(DM + 4);
		chk({term_strong_o, term_weak_o}, 2'h0);
		mode(MODE_NORMAL);
		chk({term_strong_o, term_weak_o}, 2'h2);
		settle(DM + 4);
		chk({term_strong_o, term_weak_o}, 2'h1);
		u_lintc_bus_node.clamp(1'h1);
		settle(3);
		summarize();
	end
endmodule : lintc_core_bench
